// ==== pkg/tx_dma_pkg.sv ====
// Constants shared by the transmit channel control block
package tx_dma_pkg;
  localparam int NUM_CH = 24;
  localparam int NUM_PORT = 4;
  localparam int CHW = 5;
  localparam int PW = 2;
  localparam int DW = 64;
  localparam int AW = 20;
  // Address spaces selected by pio_space
  localparam logic [1:0] SPACE_TXC = 2'h0;
  localparam logic [1:0] SPACE_BURST = 2'h1;
  localparam logic [1:0] SPACE_DMC = 2'h2;
  localparam logic [1:0] SPACE_PAGE = 2'h3;
  // Offsets and strides
  localparam logic [AW-1:0] OFS_TX_CONTROLLER_CONTROL = 20'h20000;
  localparam logic [AW-1:0] OFS_PORT_LIST = 20'h20028;
  localparam logic [AW-1:0] OFS_CS = 20'h40028;
  localparam int CH_LSB = 9;
  localparam int PORT_LSB = 8;
  // Channel status and control bit positions
  localparam int CS_RST_REQ = 31;
  localparam int CS_RST_STATE = 30;
  localparam int CS_STOP_REQ = 28;
  localparam int CS_STOPPED = 27;
  localparam int CTL_ENABLE = 4;
  localparam logic RST_STATE_POR = 1'b1;
  localparam logic [4:0] CONTROL_POR = 5'h00;
  // Per-channel configuration registers: ring, mailbox, kick, burst, two pages
  localparam int NUM_CFG = 14;
  localparam logic [AW-1:0] CFG_OFS [NUM_CFG] = '{
    20'h40000, 20'h40030, 20'h40038, 20'h40018, 20'h20000, 20'h40000, 20'h40008,
    20'h40048, 20'h40010, 20'h40050, 20'h40028, 20'h40068, 20'h40038, 20'h40078};
  localparam logic [1:0] CFG_SPACE [NUM_CFG] = '{
    SPACE_DMC, SPACE_DMC, SPACE_DMC, SPACE_DMC, SPACE_BURST, SPACE_PAGE, SPACE_PAGE,
    SPACE_PAGE, SPACE_PAGE, SPACE_PAGE, SPACE_PAGE, SPACE_PAGE, SPACE_PAGE, SPACE_PAGE};
  // Writable field masks; unmasked bits read as zero
  localparam logic [DW-1:0] CFG_MASK [NUM_CFG] = '{
    64'h1fff_0fff_ffff_ffc0, 64'h0000_0fff_fff8_0000, 64'h0000_0000_ffff_ffc0,
    64'h0000_0000_000f_fff8, 64'h0000_0000_000f_ffff, 64'h0000_0000_0000_000f,
    64'h0000_0000_ffff_ffff, 64'h0000_0000_ffff_ffff, 64'h0000_0000_ffff_ffff,
    64'h0000_0000_ffff_ffff, 64'h0000_0000_ffff_ffff, 64'h0000_0000_ffff_ffff,
    64'h0000_0000_000f_ffff, 64'h0000_0000_000f_ffff};
  localparam int FIFO_W = DW + 1 + PW + CHW;
endpackage : tx_dma_pkg

// ==== core/tx_dma_channel_control.sv ====
// Transmit channel control, port binding and the outgoing word FIFO
//
// Summary of operation
// - Hardware reset puts every channel in reset state and disables the controller.
// - Soft reset: set bit 31, clear bit 28, poll bit 30 high.
// - A bound channel stops on bit 28 and reports bit 27; unbound never stops.
// - Controller has port enables [3:0], enable bit 4, writable together.
// - Port channel list binds channel x by bit x; 20-bit max burst per channel.
// - Channel lists may change at run time through read-modify-write.
// - Each channel holds ring length, base and start address; copies 0x200 apart.
// - Each channel holds mailbox address high [43:19] and low [31:6].
// - Page tables: function, two valid bits, mask, value, relocation, handle.
// - Clearing in-reset state bit 30 lets the channel transmit.
// - Disable and stop take effect only at a packet boundary.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module tx_word_fifo #(
  parameter int W = 72,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW-1:0] nxt_wp = (wp_ff == AW'(D - 1)) ? '0 : wp_ff + 1'b1;
  wire [AW-1:0] nxt_rp = (rp_ff == AW'(D - 1)) ? '0 : rp_ff + 1'b1;

  // Full and empty straight from the occupancy count
  assign in_ready = (cnt_ff != (AW + 1)'(D));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rp_ff];

  // Storage is not reset; only the pointers and the count need a defined value
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wp_ff <= nxt_wp;
      if (pop) rp_ff <= nxt_rp;
      cnt_ff <= cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  fifo_full_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cnt_ff == (AW + 1)'(D)) |-> !in_ready ##1 $stable(wp_ff))
    else $error("fifo accepted a word while full");
endmodule : tx_word_fifo

////////////////////////////////////////////////////////////////////////////////
module tx_dma_channel_control #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pio_rd,
  input wire logic pio_wr,
  input wire logic [1:0] pio_space,
  input wire logic [tx_dma_pkg::AW-1:0] pio_addr,
  input wire logic [tx_dma_pkg::DW-1:0] pio_wdata,
  output logic [tx_dma_pkg::DW-1:0] pio_rdata,
  output logic pio_rdack,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [tx_dma_pkg::CHW-1:0] src_chan,
  input wire logic [tx_dma_pkg::DW-1:0] src_data,
  input wire logic src_last,
  output logic mac_valid,
  input wire logic mac_ready,
  output logic [tx_dma_pkg::DW-1:0] mac_data,
  output logic mac_last,
  output logic [tx_dma_pkg::PW-1:0] mac_port,
  output logic [tx_dma_pkg::CHW-1:0] mac_chan
);
  import tx_dma_pkg::*;

  // First port whose list holds the channel; software keeps it to one port
  function automatic logic [PW-1:0] port_pick(input logic [NUM_PORT-1:0] col);
    logic [PW-1:0] p;
    p = '0;
    for (int i = NUM_PORT - 1; i >= 0; i--) begin
      if (col[i]) p = PW'(i);
    end
    return p;
  endfunction : port_pick

  // Channel register decode: same base and low offset, channel in between
  function automatic logic chan_hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
    return (a[AW-1:CH_LSB+CHW] == ofs[AW-1:CH_LSB+CHW]) && (a[CH_LSB-1:0] == ofs[CH_LSB-1:0])
      && (a[CH_LSB+CHW-1:CH_LSB] < CHW'(NUM_CH));
  endfunction : chan_hit

  logic [DW-1:0] cfg_ff [NUM_CFG][NUM_CH];
  logic [NUM_CH-1:0] list_ff [NUM_PORT];
  logic [4:0] ctrl_ff;
  logic [NUM_CH-1:0] rst_req_ff, rst_state_ff, stop_req_ff, stopped_ff, inprog_ff;
  logic [NUM_CH-1:0] nxt_rst_req, nxt_rst_state, nxt_stop_req, nxt_stopped, nxt_inprog;
  logic [PW-1:0] pkt_port_ff [NUM_CH];
  logic [PW-1:0] nxt_pkt_port [NUM_CH];
  logic [PW-1:0] port_of [NUM_CH];
  logic [NUM_CH-1:0] bound_w, active_w;
  logic [NUM_CFG-1:0] cfg_hit_w;
  logic [DW-1:0] rd_w;
  logic [DW-1:0] rdata_ff;
  logic rdack_ff;
  logic fifo_ready;
  logic [FIFO_W-1:0] fifo_out;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire [CHW-1:0] ch_w = pio_addr[CH_LSB+CHW-1:CH_LSB];
  wire [PW-1:0] port_w = pio_addr[PORT_LSB+PW-1:PORT_LSB];
  wire ctrl_hit = (pio_space == SPACE_TXC) && (pio_addr == OFS_TX_CONTROLLER_CONTROL);
  wire list_hit = (pio_space == SPACE_TXC)
    && (pio_addr[AW-1:PORT_LSB+PW] == OFS_PORT_LIST[AW-1:PORT_LSB+PW])
    && (pio_addr[PORT_LSB-1:0] == OFS_PORT_LIST[PORT_LSB-1:0]);
  wire cs_hit = (pio_space == SPACE_DMC) && chan_hit(pio_addr, OFS_CS);
  wire ctrl_en = ctrl_ff[CTL_ENABLE];
  wire [NUM_PORT-1:0] port_en = ctrl_ff[NUM_PORT-1:0];

  // Configuration register hits, one per kind
  genvar k;
  generate
    for (k = 0; k < NUM_CFG; k++) begin : g_hit
      assign cfg_hit_w[k] = (pio_space == CFG_SPACE[k]) && chan_hit(pio_addr, CFG_OFS[k]);
    end
  endgenerate

  // Configuration stores; the mask keeps undefined bits at zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        for (int j = 0; j < NUM_CH; j++) cfg_ff[i][j] <= '0;
      end
    end else if (pio_wr) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        if (cfg_hit_w[i]) cfg_ff[i][ch_w] <= pio_wdata & CFG_MASK[i];
      end
    end
  end

  // Controller control and port lists; lists may change while traffic runs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff <= CONTROL_POR;
      for (int i = 0; i < NUM_PORT; i++) list_ff[i] <= '0;
    end else if (pio_wr) begin
      if (ctrl_hit) ctrl_ff <= pio_wdata[4:0];
      if (list_hit) list_ff[port_w] <= pio_wdata[NUM_CH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel control: reset, stop and packet tracking
  wire src_ok = src_chan < CHW'(NUM_CH);
  wire acc = src_valid & src_ready;
  genvar c, p;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      logic [NUM_PORT-1:0] col;
      for (p = 0; p < NUM_PORT; p++) begin : g_col
        assign col[p] = list_ff[p][c];
      end
      wire wr_cs = pio_wr && cs_hit && (ch_w == CHW'(c));
      wire acc_c = acc && (src_chan == CHW'(c));
      // Reset completes only once bound and idle at a packet boundary
      wire done_rst = rst_req_ff[c] && bound_w[c] && !inprog_ff[c];
      assign bound_w[c] = |col;
      assign port_of[c] = port_pick(col);
      assign active_w[c] = !rst_state_ff[c] && !rst_req_ff[c] && !stop_req_ff[c] && ctrl_en
        && port_en[port_of[c]] && bound_w[c];
      // Request set by software wins over completion in the same cycle
      assign nxt_rst_req[c] = (wr_cs && pio_wdata[CS_RST_REQ]) ? 1'b1 :
        done_rst ? 1'b0 : rst_req_ff[c];
      // Hardware entering reset wins over a software clear
      assign nxt_rst_state[c] = done_rst ? 1'b1 :
        (wr_cs && !pio_wdata[CS_RST_STATE]) ? 1'b0 : rst_state_ff[c];
      assign nxt_stop_req[c] = wr_cs ? pio_wdata[CS_STOP_REQ] : stop_req_ff[c];
      // Stop acknowledged only when bound and no packet is half sent
      assign nxt_stopped[c] = stop_req_ff[c] && bound_w[c] && !inprog_ff[c];
      assign nxt_inprog[c] = acc_c ? !src_last : inprog_ff[c];
      assign nxt_pkt_port[c] = (acc_c && !inprog_ff[c]) ? port_of[c] : pkt_port_ff[c];
    end
  endgenerate

  // Channel state registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_req_ff <= '0;
      rst_state_ff <= {NUM_CH{RST_STATE_POR}};
      stop_req_ff <= '0;
      stopped_ff <= '0;
      inprog_ff <= '0;
      for (int i = 0; i < NUM_CH; i++) pkt_port_ff[i] <= '0;
    end else begin
      rst_req_ff <= nxt_rst_req;
      rst_state_ff <= nxt_rst_state;
      stop_req_ff <= nxt_stop_req;
      stopped_ff <= nxt_stopped;
      inprog_ff <= nxt_inprog;
      pkt_port_ff <= nxt_pkt_port;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, answered one cycle after the strobe
  always_comb begin
    rd_w = '0;
    for (int i = 0; i < NUM_CFG; i++) begin
      if (cfg_hit_w[i]) rd_w = rd_w | cfg_ff[i][ch_w];
    end
    if (cs_hit) begin
      rd_w[CS_RST_REQ] = rst_req_ff[ch_w];
      rd_w[CS_RST_STATE] = rst_state_ff[ch_w];
      rd_w[CS_STOP_REQ] = stop_req_ff[ch_w];
      rd_w[CS_STOPPED] = stopped_ff[ch_w];
    end
    if (ctrl_hit) rd_w[4:0] = ctrl_ff;
    if (list_hit) rd_w[NUM_CH-1:0] = list_ff[port_w];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= '0;
      rdack_ff <= 1'b0;
    end else begin
      rdack_ff <= pio_rd;
      if (pio_rd) rdata_ff <= rd_w;
    end
  end

  assign pio_rdata = rdata_ff;
  assign pio_rdack = rdack_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Data path: a packet already started always finishes, even after stop
  wire chan_go = src_ok && (inprog_ff[src_chan] || active_w[src_chan]);
  wire [PW-1:0] word_port = inprog_ff[src_chan] ? pkt_port_ff[src_chan] : port_of[src_chan];
  assign src_ready = fifo_ready && chan_go;

  tx_word_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(src_valid && chan_go),
    .in_ready(fifo_ready),
    .in_data({src_chan, word_port, src_last, src_data}),
    .out_valid(mac_valid),
    .out_ready(mac_ready),
    .out_data(fifo_out)
  );

  assign mac_data = fifo_out[DW-1:0];
  assign mac_last = fifo_out[DW];
  assign mac_port = fifo_out[DW+PW:DW+1];
  assign mac_chan = fifo_out[FIFO_W-1:DW+PW+1];

  ////////////////////////////////////////////////////////////////////////////
  // Checks on channel 0, the controller and every accepted word
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  stop_ack_a: assert property (stop_req_ff[0] && bound_w[0] && !inprog_ff[0]
    && $stable(stop_req_ff[0]) |=> stopped_ff[0])
    else $error("bound idle channel did not report stopped");
  unbound_nostop_a: assert property (!bound_w[0] |=> !stopped_ff[0])
    else $error("unbound channel reported stopped");
  reset_done_a: assert property (rst_req_ff[0] && bound_w[0] && !inprog_ff[0]
    && !(pio_wr && cs_hit && ch_w == 5'h00) |=> rst_state_ff[0] && !rst_req_ff[0])
    else $error("soft reset did not complete");
  stop_boundary_a: assert property (stopped_ff[0] |-> !inprog_ff[0])
    else $error("channel stopped in mid packet");
  accept_gate_a: assert property (acc |-> inprog_ff[src_chan]
    || (!rst_state_ff[src_chan] && !stop_req_ff[src_chan] && ctrl_en))
    else $error("word accepted from an inactive channel");
  rst_set_wins_a: assert property (rst_req_ff[0] && bound_w[0] && !inprog_ff[0]
    && pio_wr && cs_hit && ch_w == 5'h00 && !pio_wdata[CS_RST_STATE] |=> rst_state_ff[0])
    else $error("clear of in-reset state beat the hardware set");
  ctrl_write_a: assert property (pio_wr && ctrl_hit |=> ctrl_ff == $past(pio_wdata[4:0]))
    else $error("controller control write not taken");
  ctrl_hold_a: assert property (!(pio_wr && ctrl_hit) |=> $stable(ctrl_ff))
    else $error("controller control changed without a write");
  cs_read_a: assert property (pio_rd && cs_hit && ch_w == 5'h00 |=> pio_rdack
    && pio_rdata[CS_RST_STATE] == $past(rst_state_ff[0])
    && pio_rdata[CS_STOPPED] == $past(stopped_ff[0]))
    else $error("status read returned wrong state");
  list_port_a: assert property (acc && !inprog_ff[src_chan] |-> bound_w[src_chan]
    && port_en[word_port])
    else $error("packet started on an unbound or disabled port");

  stop_seen_c: cover property (stop_req_ff[0] ##[1:20] stopped_ff[0]);
  reset_seen_c: cover property (rst_req_ff[0] ##[1:20] rst_state_ff[0] && !rst_req_ff[0]);
  packet_seen_c: cover property (acc && !src_last ##[1:20] acc && src_last);
  fifo_full_c: cover property (src_valid && !fifo_ready);
endmodule : tx_dma_channel_control

// ==== tb/mac_sink_model.sv ====
// Transmit MAC model that takes words from the block, with random or commanded stalls
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module mac_sink_model (
  input wire logic clk,
  input wire logic hold,
  output logic mac_ready
);
  // Ready moves only at the falling edge, so the block always sees a settled value.
  // Random stalls keep back-pressure on the FIFO; hold stops draining to fill it.
  initial mac_ready = 1'b0;
  always @(negedge clk) begin
    mac_ready <= !hold && ($urandom_range(0, 3) != 0);
  end
endmodule : mac_sink_model

// ==== tb/test_tx_dma_channel_control.sv ====
// Self-checking bench: register map, channel handshakes and the outgoing word stream
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module test_tx_dma_channel_control;
  import tx_dma_pkg::*;
  localparam int DEPTH = 16;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic pio_rd = 1'b0;
  logic pio_wr = 1'b0;
  logic [1:0] pio_space = 2'h0;
  logic [AW-1:0] pio_addr = '0;
  logic [DW-1:0] pio_wdata = '0;
  logic [DW-1:0] src_data = '0;
  logic [DW-1:0] pio_rdata, mac_data, d;
  logic pio_rdack, src_ready, mac_valid, mac_ready, mac_last;
  logic src_valid = 1'b0;
  logic src_last = 1'b0;
  logic hold = 1'b0;
  logic [CHW-1:0] src_chan = '0;
  logic [CHW-1:0] mac_chan;
  logic [PW-1:0] mac_port;
  logic [FIFO_W-1:0] exp_q[$];
  logic [DW-1:0] cfg_exp[NUM_CFG];
  int bport[NUM_CH];
  int mismatches = 0;
  int checked = 0;
  int a, b, u, p, n;

  always #2.5 clk = ~clk;

  tx_dma_channel_control #(.FIFO_DEPTH(DEPTH)) tx_dma_channel_control_inst (
    .clk(clk), .sys_rst(sys_rst), .pio_rd(pio_rd), .pio_wr(pio_wr),
    .pio_space(pio_space), .pio_addr(pio_addr), .pio_wdata(pio_wdata),
    .pio_rdata(pio_rdata), .pio_rdack(pio_rdack), .src_valid(src_valid),
    .src_ready(src_ready), .src_chan(src_chan), .src_data(src_data), .src_last(src_last),
    .mac_valid(mac_valid), .mac_ready(mac_ready), .mac_data(mac_data),
    .mac_last(mac_last), .mac_port(mac_port), .mac_chan(mac_chan));
  mac_sink_model mac_sink_model_inst (.clk(clk), .hold(hold), .mac_ready(mac_ready));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [FIFO_W-1:0] seen, input logic [FIFO_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // Register bus: one-cycle strobes, read answer one cycle after the strobe
  task automatic wr(input logic [1:0] sp, input logic [AW-1:0] ad, input logic [DW-1:0] wd);
    @(negedge clk);
    pio_space = sp;
    pio_addr = ad;
    pio_wdata = wd;
    pio_wr = 1'b1;
    @(negedge clk);
    pio_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] sp, input logic [AW-1:0] ad, output logic [DW-1:0] rv);
    @(negedge clk);
    pio_space = sp;
    pio_addr = ad;
    pio_rd = 1'b1;
    @(negedge clk);
    pio_rd = 1'b0;
    check(pio_rdack, 1'b1);
    rv = pio_rdata;
  endtask : rd

  function automatic logic [AW-1:0] cs_a(input int c);
    return OFS_CS + AW'(c << CH_LSB);
  endfunction : cs_a

  // Offer one word and hold it until taken; valid stays up for back-to-back words
  task automatic send(input int c, input logic l);
    @(negedge clk);
    src_valid = 1'b1;
    src_chan = CHW'(c);
    src_data = {$urandom, $urandom};
    src_last = l;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (src_ready !== 1'b1 && n < 200);
    if (src_ready !== 1'b1) check(1'b0, 1'b1);
  endtask : send

  task automatic drop();
    @(negedge clk);
    src_valid = 1'b0;
  endtask : drop

  // A word offered on a channel that may not start a packet must stay refused
  task automatic refuse(input int c);
    @(negedge clk);
    src_valid = 1'b1;
    src_chan = CHW'(c);
    src_last = 1'b1;
    repeat (3) @(posedge clk) check(src_ready, 1'b0);
    drop();
  endtask : refuse

  // Scoreboard: every taken word must leave in order with its bound port
  always @(posedge clk) begin
    if (src_valid && src_ready)
      exp_q.push_back({src_data, src_last, PW'(bport[src_chan]), src_chan});
    if (mac_valid && mac_ready) begin
      if (exp_q.size() == 0) check(1'b1, 1'b0);
      else check({mac_data, mac_last, mac_port, mac_chan}, exp_q.pop_front());
    end
  end

  // Watchdog sized well above the whole sequence
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h5c950dd5));
    repeat (4) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    for (int c = 0; c < NUM_CH; c++) bport[c] = 0;
    rd(SPACE_DMC, cs_a(0), d);
    check(d[CS_RST_STATE], RST_STATE_POR);
    rd(SPACE_DMC, cs_a(23), d);
    check(d[CS_RST_STATE], 1'b1);
    rd(SPACE_TXC, OFS_TX_CONTROLLER_CONTROL, d);
    check(d[4:0], CONTROL_POR);
    wr(SPACE_TXC, 20'h20008, 64'hffff_ffff_ffff_ffff);
    rd(SPACE_TXC, 20'h20008, d);
    check(d, 64'h0);
    $display("test reset done");
    // Channel 0 carries the traffic so the block's own checks on it are exercised
    a = 0;
    for (int i = 0; i < NUM_CFG; i++) begin
      cfg_exp[i] = {$urandom, $urandom};
      wr(CFG_SPACE[i], CFG_OFS[i] + AW'(a << CH_LSB), cfg_exp[i]);
      cfg_exp[i] &= CFG_MASK[i];
    end
    for (int i = 0; i < NUM_CFG; i++) begin
      rd(CFG_SPACE[i], CFG_OFS[i] + AW'(a << CH_LSB), d);
      check(d, cfg_exp[i]);
    end
    $display("test config done");
    wr(SPACE_TXC, OFS_TX_CONTROLLER_CONTROL, 64'h1f);
    rd(SPACE_TXC, OFS_TX_CONTROLLER_CONTROL, d);
    check(d, 64'h1f);
    b = a + 12;
    u = a + 1;
    p = $urandom_range(0, 3);
    for (int k = 0; k < 2; k++) begin
      n = (k == 0) ? a : b;
      rd(SPACE_TXC, OFS_PORT_LIST + AW'(p << PORT_LSB), d);
      wr(SPACE_TXC, OFS_PORT_LIST + AW'(p << PORT_LSB), d | (64'h1 << n));
      bport[n] = p;
    end
    rd(SPACE_TXC, OFS_PORT_LIST + AW'(p << PORT_LSB), d);
    check(d, (64'h1 << a) | (64'h1 << b));
    wr(SPACE_DMC, CFG_OFS[3] + AW'(a << CH_LSB), 64'h0);
    wr(SPACE_DMC, cs_a(a), 64'h0);
    rd(SPACE_DMC, cs_a(a), d);
    check(d[CS_RST_STATE], 1'b0);
    send(a, 1'b0);
    send(a, 1'b0);
    send(a, 1'b1);
    drop();
    refuse(b);
    $display("test traffic done");
    send(a, 1'b0);
    drop();
    wr(SPACE_DMC, cs_a(a), 64'h1 << CS_STOP_REQ);
    repeat (3) @(posedge clk);
    rd(SPACE_DMC, cs_a(a), d);
    check(d[CS_STOPPED], 1'b0);
    send(a, 1'b1);
    drop();
    repeat (3) @(posedge clk);
    rd(SPACE_DMC, cs_a(a), d);
    check(d[CS_STOPPED], 1'b1);
    refuse(a);
    wr(SPACE_DMC, cs_a(a), 64'h1 << CS_RST_REQ);
    n = 0;
    do begin
      rd(SPACE_DMC, cs_a(a), d);
      n++;
    end while (d[CS_RST_STATE] !== 1'b1 && n < 10);
    check({d[CS_RST_REQ], d[CS_RST_STATE], d[CS_STOPPED]}, 3'b010);
    refuse(a);
    wr(SPACE_DMC, cs_a(u), 64'h0);
    wr(SPACE_DMC, cs_a(u), 64'h1 << CS_STOP_REQ);
    repeat (5) @(posedge clk);
    rd(SPACE_DMC, cs_a(u), d);
    check(d[CS_STOPPED], 1'b0);
    refuse(u);
    $display("test stop and reset done");
    wr(SPACE_DMC, CFG_OFS[3] + AW'(a << CH_LSB), 64'h0);
    wr(SPACE_DMC, cs_a(a), 64'h0);
    hold = 1'b1;
    repeat (3) @(negedge clk);
    for (int i = 0; i < DEPTH; i++) send(a, 1'b0);
    drop();
    refuse(a);
    hold = 1'b0;
    send(a, 1'b1);
    drop();
    n = 0;
    while (exp_q.size() != 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
    check(exp_q.size(), 0);
    check(mac_valid, 1'b0);
    wr(SPACE_TXC, OFS_TX_CONTROLLER_CONTROL, 64'h0f);
    refuse(a);
    $display("test fifo and disable done");
    print_verdict();
  end
endmodule : test_tx_dma_channel_control
